// File: core/oct_timer.sv
// Purpose: Output compare timer channel 0 with two compare pins
// Assumes: Register port with one-cycle strobes, reads answered next cycle
// Notes: Counter 1 lives elsewhere; only its start bit is held here
`timescale 1ns/1ps

module oct_timer
  import oct_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ext_clk,
  input wire logic [15:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe,
  output logic run_ch1
);

  typedef struct packed {
    logic [7:0] timer_control_ch0;
    logic [7:0] io_control_a_ch0;
    logic [15:0] up_counter_ch0;
    logic [15:0] compare_a_ch0;
    logic [15:0] compare_b_ch0;
    logic [1:0] start_register;
    logic sync_mode_register;
    logic pwm_select_register;
    logic [1:0] function_control_register;
    logic [1:0] pin_enable;
    logic [1:0] initial_level_register;
    logic [1:0] pin_level;
    logic [1:0] match_flag;
    logic [15:0] rdat;
  } oct_state_t;

  oct_state_t st_reg;
  oct_state_t st_next;
  oct_tick_if tk ();
  logic run0;
  logic step;
  logic ma;
  logic mb;
  logic clr;
  logic [1:0] cclr;

  function automatic logic oc_level(input logic [2:0] code, input logic cur);
    case (code)
      IO_LOW: oc_level = 1'b0;
      IO_HIGH: oc_level = 1'b1;
      IO_TOGGLE: oc_level = !cur;
      default: oc_level = cur;
    endcase
  endfunction : oc_level

  // ----------------------------------------------------------------
  // Clock source
  // ----------------------------------------------------------------
  assign tk.div_sel = st_reg.timer_control_ch0[TPSC_LSB +: 3];
  assign tk.edge_sel = st_reg.timer_control_ch0[CKEG_LSB +: 2];

  oct_prescaler u_pre (
    .mclk (mclk),
    .rstn (rstn),
    .ext_clk (ext_clk),
    .tk (tk)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    // Synchronous mode lets either start bit run counter 0; run_ch1 still follows start bit 1 only
    if (st_reg.sync_mode_register)
      run0 = |st_reg.start_register;
    else
      run0 = st_reg.start_register[0];
    step = run0 && tk.tick;
    ma = step && (st_reg.up_counter_ch0 == st_reg.compare_a_ch0);
    mb = step && (st_reg.up_counter_ch0 == st_reg.compare_b_ch0);
    cclr = st_reg.timer_control_ch0[CCLR_LSB +: 2];
    clr = (cclr == CCLR_ON_A && ma) || (cclr == CCLR_ON_B && mb);

    // Counting; the 16-bit add wraps on its own
    if (step)
    begin
      if (clr)
        st_next.up_counter_ch0 = RST_CNT;
      else
        st_next.up_counter_ch0 = st_reg.up_counter_ch0 + 16'h0001;
    end

    // Pin levels follow matches only in normal channel mode
    if (st_reg.function_control_register == CMB_NORMAL)
    begin
      if (ma)
        st_next.pin_level[0] = oc_level(st_reg.io_control_a_ch0[IOA_LSB +: 3],
          st_reg.pin_level[0]);
      if (st_reg.pwm_select_register)
      begin
        if (ma)
          st_next.pin_level[1] = 1'b0;
        if (mb)
          st_next.pin_level[1] = 1'b1;
      end
      else if (mb)
      begin
        st_next.pin_level[1] = oc_level(st_reg.io_control_a_ch0[IOB_LSB +: 3],
          st_reg.pin_level[1]);
      end
    end

    // Register writes; a counter write beats the count step
    if (wr_en)
    begin
      case (addr)
        OFS_CTRL: st_next.timer_control_ch0 = wr_data[7:0];
        OFS_IOC: st_next.io_control_a_ch0 = wr_data[7:0];
        OFS_CNT: st_next.up_counter_ch0 = wr_data;
        OFS_CMPA: st_next.compare_a_ch0 = wr_data;
        OFS_CMPB: st_next.compare_b_ch0 = wr_data;
        OFS_START: st_next.start_register = wr_data[1:0];
        OFS_SYNC: st_next.sync_mode_register = wr_data[0];
        OFS_PWM: st_next.pwm_select_register = wr_data[0];
        OFS_FUNC: st_next.function_control_register = wr_data[1:0];
        OFS_OEN:
        begin
          st_next.pin_enable = ~wr_data[1:0];
          // A pin newly enabled starts from its initial level
          for (int i = 0; i < 2; i++)
          begin
            if (!st_reg.pin_enable[i] && !wr_data[i])
              st_next.pin_level[i] = st_reg.initial_level_register[i];
          end
        end
        OFS_INIT:
        begin
          st_next.initial_level_register = wr_data[1:0];
          st_next.pin_level = wr_data[1:0];
        end
        OFS_FLAG: st_next.match_flag = st_reg.match_flag & wr_data[1:0];
        default: ;
      endcase
    end

    // Sticky match flags; a new match wins over a clear
    st_next.match_flag = st_next.match_flag | {mb, ma};

    // Read data stand for exactly one cycle after the strobe
    st_next.rdat = 16'h0000;
    if (rd_en)
    begin
      case (addr)
        OFS_CTRL: st_next.rdat = {8'h00, st_reg.timer_control_ch0};
        OFS_IOC: st_next.rdat = {8'h00, st_reg.io_control_a_ch0};
        OFS_CNT: st_next.rdat = st_reg.up_counter_ch0;
        OFS_CMPA: st_next.rdat = st_reg.compare_a_ch0;
        OFS_CMPB: st_next.rdat = st_reg.compare_b_ch0;
        OFS_START: st_next.rdat = {14'h0000, st_reg.start_register};
        OFS_SYNC: st_next.rdat = {15'h0000, st_reg.sync_mode_register};
        OFS_PWM: st_next.rdat = {15'h0000, st_reg.pwm_select_register};
        OFS_FUNC: st_next.rdat = {14'h0000, st_reg.function_control_register};
        OFS_OEN: st_next.rdat = {14'h0000, ~st_reg.pin_enable};
        OFS_INIT: st_next.rdat = {14'h0000, st_reg.initial_level_register};
        OFS_FLAG: st_next.rdat = {14'h0000, st_reg.match_flag};
        default: st_next.rdat = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '{RST_CTRL, RST_IOC, RST_CNT, RST_CMP, RST_CMP, RST_START, 1'b0,
        1'b0, RST_FUNC, RST_OEN, RST_INIT, RST_INIT, 2'h0, 16'h0000};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data = st_reg.rdat;
  assign pin_a_out = st_reg.pin_level[0];
  assign pin_b_out = st_reg.pin_level[1];
  assign pin_a_oe = st_reg.pin_enable[0];
  assign pin_b_oe = st_reg.pin_enable[1];
  assign run_ch1 = st_reg.start_register[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_no_clear;
    step && cclr == 2'h0 && !(wr_en && addr == OFS_CNT) && st_reg.up_counter_ch0 != 16'hffff
      |=> st_reg.up_counter_ch0 == $past(st_reg.up_counter_ch0) + 16'h0001;
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("counter cleared or skipped");

  property p_wrap;
    step && st_reg.up_counter_ch0 == 16'hffff && cclr == 2'h0 && !wr_en
      |=> st_reg.up_counter_ch0 == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

  property p_b_high;
    mb && st_reg.io_control_a_ch0[IOB_LSB +: 3] == IO_HIGH && !st_reg.pwm_select_register
      && st_reg.function_control_register == CMB_NORMAL && !wr_en |=> pin_b_out;
  endproperty
  a_b_high: assert property (p_b_high) else $error("pin B not high after match");

  property p_a_low;
    ma && st_reg.io_control_a_ch0[IOA_LSB +: 3] == IO_LOW
      && st_reg.function_control_register == CMB_NORMAL && !wr_en |=> !pin_a_out;
  endproperty
  a_a_low: assert property (p_a_low) else $error("pin A not low after match");

  property p_stopped;
    (st_reg.start_register == 2'h0 && !wr_en) [*2]
      |-> $stable(st_reg.up_counter_ch0) [*2];
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved");

  property p_oe_low;
    wr_en && addr == OFS_OEN |=> pin_a_oe == !$past(wr_data[0])
      && pin_b_oe == !$past(wr_data[1]);
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("enable polarity wrong");

  property p_init;
    wr_en && addr == OFS_INIT |=> pin_a_out == $past(wr_data[0])
      && pin_b_out == $past(wr_data[1]);
  endproperty
  a_init: assert property (p_init) else $error("initial level not driven");

  property p_match_a;
    step && st_reg.up_counter_ch0 == st_reg.compare_a_ch0 ##1 !(wr_en && addr == OFS_FLAG)
      |-> st_reg.match_flag[0] ##1 st_reg.match_flag[0];
  endproperty
  a_match_a: assert property (p_match_a) else $error("match A flag lost");

  property p_read;
    rd_en && addr == OFS_CNT |=> rd_data == $past(st_reg.up_counter_ch0) ##1 rd_data == 16'h0000
      || $past(rd_en);
  endproperty
  a_read: assert property (p_read) else $error("counter read wrong");

  property p_rd_idle;
    !rd_en |=> rd_data == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

  property p_match_b;
    step && st_reg.up_counter_ch0 == st_reg.compare_b_ch0 |=> st_reg.match_flag[1];
  endproperty
  a_match_b: assert property (p_match_b) else $error("match B flag lost");

  property p_pwm_b;
    ma && !mb && st_reg.pwm_select_register && st_reg.function_control_register == CMB_NORMAL
      && !wr_en |=> !pin_b_out;
  endproperty
  a_pwm_b: assert property (p_pwm_b) else $error("pwm pin B not low");

  property p_combined;
    st_reg.function_control_register != CMB_NORMAL && !wr_en
      |=> pin_a_out == $past(pin_a_out) && pin_b_out == $past(pin_b_out);
  endproperty
  a_combined: assert property (p_combined) else $error("pin moved in combined mode");

  property p_oe_hold;
    !(wr_en && addr == OFS_OEN) |=> $stable(pin_a_oe) && $stable(pin_b_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("enable moved without write");

  property p_load_a;
    wr_en && addr == OFS_OEN && !pin_a_oe && !wr_data[0]
      |=> pin_a_out == $past(st_reg.initial_level_register[0]);
  endproperty
  a_load_a: assert property (p_load_a) else $error("pin A not at initial level");

  property p_load_b;
    wr_en && addr == OFS_OEN && !pin_b_oe && !wr_data[1]
      |=> pin_b_out == $past(st_reg.initial_level_register[1]);
  endproperty
  a_load_b: assert property (p_load_b) else $error("pin B not at initial level");

  property p_run_ch1;
    wr_en && addr == OFS_START |=> run_ch1 == $past(wr_data[1]);
  endproperty
  a_run_ch1: assert property (p_run_ch1) else $error("counter 1 start wrong");

  property p_indep;
    !st_reg.sync_mode_register && !st_reg.start_register[0] && !wr_en
      |=> $stable(st_reg.up_counter_ch0);
  endproperty
  a_indep: assert property (p_indep) else $error("independent counter moved");

  property p_sync_run;
    st_reg.sync_mode_register && st_reg.start_register == 2'h2 && tk.tick && cclr == 2'h0
      && !wr_en |=> st_reg.up_counter_ch0 == $past(st_reg.up_counter_ch0) + 16'h0001;
  endproperty
  a_sync_run: assert property (p_sync_run) else $error("sync count missed a step");

  c_match_a: cover property (ma && !pin_a_out ##1 pin_a_out == 1'b0);
  c_match_b: cover property (mb ##1 pin_b_out);
  c_wrap: cover property (step && st_reg.up_counter_ch0 == 16'hffff);
  c_pwm: cover property (st_reg.pwm_select_register && mb);
  c_sync: cover property (st_reg.sync_mode_register && step);

endmodule : oct_timer

// File: core/oct_pkg.sv
// Purpose: Shared constants for the output compare timer, channel 0
// Assumes: 16-bit register port, registers at their byte addresses
// Notes: Eight-bit registers sit in the low byte, upper byte reads zero
package oct_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_CTRL = 16'hf700;
  localparam logic [15:0] OFS_IOC = 16'hf701;
  localparam logic [15:0] OFS_CNT = 16'hf706;
  localparam logic [15:0] OFS_CMPA = 16'hf708;
  localparam logic [15:0] OFS_CMPB = 16'hf70a;
  localparam logic [15:0] OFS_START = 16'hf720;
  localparam logic [15:0] OFS_SYNC = 16'hf721;
  localparam logic [15:0] OFS_PWM = 16'hf722;
  localparam logic [15:0] OFS_FUNC = 16'hf723;
  localparam logic [15:0] OFS_OEN = 16'hf724;
  localparam logic [15:0] OFS_INIT = 16'hf725;
  localparam logic [15:0] OFS_FLAG = 16'hf726;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_IOC = 8'h00;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_CMP = 16'hffff;
  localparam logic [1:0] RST_START = 2'h0;
  localparam logic [1:0] RST_FUNC = 2'h0;
  localparam logic [1:0] RST_OEN = 2'h0;
  localparam logic [1:0] RST_INIT = 2'h0;
  localparam logic [12:0] RST_PRE = 13'h0000;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int CCLR_LSB = 5;
  localparam int CKEG_LSB = 3;
  localparam int TPSC_LSB = 0;
  localparam int IOB_LSB = 4;
  localparam int IOA_LSB = 0;
  localparam int PRE_W = 13;
  localparam logic [1:0] CCLR_ON_A = 2'h1;
  localparam logic [1:0] CCLR_ON_B = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [2:0] IO_LOW = 3'h1;
  localparam logic [2:0] IO_HIGH = 3'h2;
  localparam logic [2:0] IO_TOGGLE = 3'h3;
  localparam logic [1:0] CMB_NORMAL = 2'h0;

endpackage : oct_pkg

// File: core/oct_tick_if.sv
// Purpose: Clock selection from the timer to its prescaler, tick back
// Assumes: One clock domain, mclk
// Notes: Tick is a one-cycle count enable
`timescale 1ns/1ps
interface oct_tick_if;
  logic [2:0] div_sel;
  logic [1:0] edge_sel;
  logic tick;
  modport src (input div_sel, input edge_sel, output tick);
  modport dst (output div_sel, output edge_sel, input tick);
endinterface : oct_tick_if

// File: core/oct_prescaler.sv
// Purpose: Free running prescaler and count enable for counter 0
// Assumes: ext_clk is asynchronous and slower than mclk / 2
// Notes: Divider codes 000..011 give mclk / 1, 2, 4, 8
`timescale 1ns/1ps
module oct_prescaler
  import oct_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ext_clk,
  oct_tick_if.src tk
);

  typedef struct packed {
    logic [PRE_W-1:0] sys_prescaler;
    logic s1;
    logic s2;
    logic s3;
    logic tick;
  } oct_pre_t;

  oct_pre_t st_reg;
  oct_pre_t st_next;
  logic rise;
  logic fall;

  function automatic logic [PRE_W-1:0] div_mask(input logic [1:0] k);
    div_mask = PRE_W'((14'h0001 << k) - 14'h0001);
  endfunction : div_mask

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.sys_prescaler = st_reg.sys_prescaler + 13'h0001;
    st_next.s1 = ext_clk;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    rise = st_reg.s2 && !st_reg.s3;
    fall = !st_reg.s2 && st_reg.s3;
    if (tk.div_sel[2])
    begin
      case (tk.edge_sel)
        EDGE_RISE: st_next.tick = rise;
        EDGE_FALL: st_next.tick = fall;
        default: st_next.tick = rise || fall;
      endcase
    end
    else
    begin
      st_next.tick = (st_reg.sys_prescaler & div_mask(tk.div_sel[1:0]))
        == div_mask(tk.div_sel[1:0]);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      st_reg <= '{RST_PRE, 1'b0, 1'b0, 1'b0, 1'b0};
    else
      st_reg <= st_next;
  end

  assign tk.tick = st_reg.tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_pre_inc;
    rstn |=> st_reg.sys_prescaler == $past(st_reg.sys_prescaler) + 13'h0001;
  endproperty
  a_pre_inc: assert property (p_pre_inc) else $error("prescaler missed a step");

  property p_half;
    (tk.div_sel == 3'h1) [*3] ##0 tk.tick ##1 tk.div_sel == 3'h1 |-> !tk.tick ##1 tk.tick;
  endproperty
  a_half: assert property (p_half) else $error("divide by two cadence wrong");

  property p_ext_rise;
    $past(tk.div_sel[2]) && $past(tk.edge_sel) == EDGE_RISE && tk.tick
      |-> $past(st_reg.s2) && !$past(st_reg.s3);
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("tick not on rising edge");

endmodule : oct_prescaler

// File: testbench/oct_pin_load.sv
// Purpose: Board load on one compare output pin
// Assumes: A weak pull resistor sits on the net
// Notes: A released pin shows the pull level, never the last driven value
`timescale 1ns/1ps
module oct_pin_load
#(
  parameter logic PULL = 1'b1
)
(
  input wire logic drive,
  input wire logic oe,
  output logic level
);
  // ----------------------------------------------------------------
  // Net resolution
  // ----------------------------------------------------------------
  assign level = oe ? drive : PULL;
endmodule : oct_pin_load

// File: testbench/output_compare_timer_bench.sv
// Purpose: Self-checking bench for the channel 0 compare timer
// Assumes: 10 MHz mclk, register port with one-cycle strobes
// Notes: Counter reads allow two counts of slack for tick latency
`timescale 1ns/1ps
module output_compare_timer_bench
  import oct_pkg::*;
;
  logic mclk, rstn, ext_clk, wr_en, rd_en;
  logic [15:0] addr, wr_data, rd_data, v;
  logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, run_ch1, lvl_a, lvl_b, pa_q, pb_q;
  int err_count, n_compared, cyc, a_fall, b_rise, k1, dk;
  integer seed;
  logic [15:0] mdl [logic [15:0]];
  logic [15:0] rst_list [5] = '{OFS_CTRL, OFS_CNT, OFS_CMPA, OFS_CMPB, OFS_START};
  logic [15:0] rw_list [9] = '{OFS_CNT, OFS_CMPA, OFS_CMPB, OFS_CTRL, OFS_SYNC, OFS_PWM,
    OFS_FUNC, OFS_INIT, 16'hf702};

  oct_timer dut
  (
    .mclk(mclk), .rstn(rstn), .ext_clk(ext_clk), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_a_out(pin_a_out),
    .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .run_ch1(run_ch1)
  );
  oct_pin_load #(.PULL(1'b1)) load_a (.drive(pin_a_out), .oe(pin_a_oe), .level(lvl_a));
  oct_pin_load #(.PULL(1'b0)) load_b (.drive(pin_b_out), .oe(pin_b_oe), .level(lvl_b));

  // ----------------------------------------------------------------
  // Clocks and pin edge monitor
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    ext_clk = 1'b0;
    forever
    begin
      repeat (7) @(posedge mclk);
      ext_clk <= ~ext_clk;
    end
  end
  always @(negedge mclk)
  begin
    cyc <= cyc + 1;
    pa_q <= pin_a_out;
    pb_q <= pin_b_out;
    if (pa_q === 1'b1 && pin_a_out === 1'b0) a_fall <= cyc;
    if (pb_q === 1'b0 && pin_b_out === 1'b1) b_rise <= cyc;
  end

  // ----------------------------------------------------------------
  // Checks, bus cycles and register model
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic near(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (((got - exp + 16'd2) > 16'd4) !== 1'b0)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : near
  function automatic logic [15:0] msk(input logic [15:0] a);
    case (a)
      OFS_CNT, OFS_CMPA, OFS_CMPB: return 16'hffff;
      OFS_CTRL, OFS_IOC: return 16'h00ff;
      OFS_START, OFS_FUNC, OFS_OEN, OFS_INIT: return 16'h0003;
      OFS_SYNC, OFS_PWM: return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction : msk
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    mdl[a] = d & msk(a);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rd_data;
    @(posedge mclk);
    #1 check("rd_data idle", 16'h0000, rd_data);
  endtask : rd
  task automatic rdchk(input logic [15:0] a);
    logic [15:0] d;
    rd(a, d);
    check($sformatf("reg %h", a), mdl.exists(a) ? mdl[a] : 16'h0000, d);
  endtask : rdchk
  task automatic run_cnt(input logic [7:0] ctl, input logic [15:0] c0, input int n);
    logic [15:0] d;
    logic [15:0] e;
    wr(OFS_CTRL, {8'h00, ctl});
    wr(OFS_CNT, c0);
    wr(OFS_START, 16'h0001);
    repeat (n) @(posedge mclk);
    wr(OFS_START, 16'h0000);
    e = c0 + 16'(ctl[2] ? (n + 2) / 14 : (n + 2) >> ctl[1:0]);
    rd(OFS_CNT, d);
    near("counter", e, d);
  endtask : run_cnt
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    final_report();
  end
  initial
  begin
    seed = 32'h6d4a;
    rstn = 1'b0;
    addr = 16'h0000;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    err_count = 0;
    n_compared = 0;
    cyc = 0;
    mdl[OFS_CMPA] = RST_CMP;
    mdl[OFS_CMPB] = RST_CMP;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    #1 check("oe after reset", 16'h0000, {14'h0, pin_b_oe, pin_a_oe});
    check("run_ch1 after reset", 16'h0000, 16'(run_ch1));
    foreach (rst_list[i])
      rdchk(rst_list[i]);
    foreach (rw_list[i])
    begin
      wr(rw_list[i], 16'($random(seed)));
      rdchk(rw_list[i]);
    end
    wr(OFS_START, 16'($random(seed)) & 16'h0002);
    #1 check("run_ch1", mdl[OFS_START] >> 1, 16'(run_ch1));
    rdchk(OFS_START);
    wr(OFS_START, 16'h0000);
    wr(OFS_SYNC, 16'h0000);
    wr(OFS_PWM, 16'h0000);
    wr(OFS_FUNC, 16'h0000);
    for (int dv = 0; dv < 5; dv++)
      run_cnt(8'(dv), 16'h0000, 140);
    k1 = 20 + ($random(seed) & 15);
    dk = 10 + ($random(seed) & 15);
    wr(OFS_IOC, 16'h0021);
    wr(OFS_CMPA, 16'(k1));
    wr(OFS_CMPB, 16'(k1 + dk));
    wr(OFS_INIT, 16'h0001);
    wr(OFS_OEN, 16'h0000);
    rdchk(OFS_IOC);
    check("pins before match", 16'h0001, {14'h0, lvl_b, lvl_a});
    check("oe enabled", 16'h0003, {14'h0, pin_b_oe, pin_a_oe});
    a_fall = -1;
    b_rise = -1;
    run_cnt(8'h01, 16'h0000, 2 * (k1 + dk) + 20);
    check("b rise after a fall", 16'(2 * dk), 16'(b_rise - a_fall));
    check("pins after match", 16'h0002, {14'h0, lvl_b, lvl_a});
    rd(OFS_FLAG, v);
    check("match flags", 16'h0003, v);
    wr(OFS_FLAG, 16'h0000);
    rd(OFS_FLAG, v);
    check("flags cleared", 16'h0000, v);
    wr(OFS_PWM, 16'h0001);
    wr(OFS_INIT, 16'h0003);
    run_cnt(8'h01, 16'h0000, 2 * k1 + 4);
    check("pwm pins after match a", 16'h0000, {14'h0, lvl_b, lvl_a});
    wr(OFS_PWM, 16'h0000);
    wr(OFS_IOC, 16'h0001);
    wr(OFS_CMPA, 16'h0005);
    wr(OFS_INIT, 16'h0001);
    a_fall = -1;
    run_cnt(8'h80, 16'hfff0, 40);
    check("match after wrap", 16'h0000, 16'(lvl_a));
    wr(OFS_OEN, 16'h0003);
    wr(OFS_INIT, 16'h0000);
    #1 check("oe off", 16'h0000, {14'h0, pin_b_oe, pin_a_oe});
    check("released", 16'h0001, {14'h0, lvl_b, lvl_a});
    wr(OFS_OEN, 16'h0002);
    #1 check("a only on", 16'h0001, {14'h0, pin_b_oe, pin_a_oe});
    check("a initial", 16'h0000, 16'(lvl_a));
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_CNT, 16'h0100);
    wr(OFS_START, 16'h0002);
    repeat (30) @(posedge mclk);
    rd(OFS_CNT, v);
    check("counter held", 16'h0100, v);
    wr(OFS_SYNC, 16'h0001);
    repeat (30) @(posedge mclk);
    wr(OFS_START, 16'h0000);
    rd(OFS_CNT, v);
    near("counter synced", 16'h0100 + 16'd32, v);
    final_report();
  end
endmodule : output_compare_timer_bench
